/* iad_top.sv */
// Indirect access sequencer: decodes the pointer and drives data memory or flash.
`timescale 1ns/1ps
`default_nettype none
`include "iad_defines.svh"

// How it works
// - Port accesses go to the location the file select pointer names.
// - Pointer naming a port location reads zero and writes nothing.
// - Address is pointer high byte over pointer low byte, sixteen bits.
// - Pointers 0x000 to 0xFFF map straight to absolute data addresses.
// - Pointers 0x2000 to 0x29AF alias the banked 80-byte RAM blocks.
// - Stepping past one bank's last RAM byte lands on the next bank.
// - Reads of unimplemented locations return 0x00.
// - Common memory bytes are left out of the linear region.
// - Top pointer bit set means the low 15 bits address flash words.
// - Flash reads deliver only the low eight bits of the word.
// - Writes into the flash region change nothing.
// - Every flash access takes one extra cycle, stalling the core.
module iad_top (
   // Clock and synchronous reset.
   input wire logic sys_clk,
   input wire logic rst,
   // Core side request and answer.
   input wire logic req_valid,
   input wire iad_pkg::iad_req_t req,
   output logic busy,
   output logic done,
   output logic stall,
   output logic [7:0] rd_data,
   // Data memory side.
   output logic [11:0] dm_addr,
   output logic dm_rd,
   output logic dm_wr,
   output logic [7:0] dm_wdata,
   input wire logic [7:0] dm_rdata,
   // Program flash side, read only.
   output logic [14:0] fl_addr,
   output logic fl_rd,
   input wire logic [13:0] fl_rdata
);

   iad_pkg::iad_dec_t dec;
   iad_pkg::iad_state_t state;
   iad_pkg::iad_state_t next_state;
   logic next_busy;
   logic next_done;
   logic next_stall;
   logic [7:0] next_rd_data;
   logic [11:0] next_dm_addr;
   logic next_dm_rd;
   logic next_dm_wr;
   logic [7:0] next_dm_wdata;
   logic [14:0] next_fl_addr;
   logic next_fl_rd;
   // Which storage answers the pending read, and whether flash was touched.
   logic src_dm;
   logic src_fl;
   logic is_flash;
   logic next_src_dm;
   logic next_src_fl;
   logic next_is_flash;
   logic take;
   logic data_ok;

   // The decoder looks at the live request pointer so it can issue next edge.
   iad_decode u_decode (
      .ptr(req.ptr),
      .dec(dec)
   );

   // A request is only taken while idle; the core must wait for done.
   assign take = req_valid && (state == iad_pkg::IAD_ST_IDLE);
   // Data memory is only reached for real storage, never for port locations.
   assign data_ok = ((dec.region == iad_pkg::IAD_REG_TRAD) ||
                     (dec.region == iad_pkg::IAD_REG_LIN)) && !dec.port_hit;

   // Next-state logic for the sequencer and every registered output.
   always_comb begin
      next_state = state;
      next_busy = busy;
      next_done = 1'b0;
      next_stall = 1'b0;
      next_rd_data = rd_data;
      next_dm_addr = dm_addr;
      next_dm_rd = 1'b0;
      next_dm_wr = 1'b0;
      next_dm_wdata = dm_wdata;
      next_fl_addr = fl_addr;
      next_fl_rd = 1'b0;
      next_src_dm = src_dm;
      next_src_fl = src_fl;
      next_is_flash = is_flash;
      case (state)
         iad_pkg::IAD_ST_IDLE: begin
            if (take) begin
               next_state = iad_pkg::IAD_ST_ISSUE;
               next_busy = 1'b1;
               next_dm_addr = dec.dm_addr;
               next_fl_addr = dec.fl_addr;
               next_dm_wdata = req.wdata;
               next_dm_rd = data_ok && !req.write;
               // Port hits and unimplemented targets never see a write strobe.
               next_dm_wr = data_ok && req.write;
               // Flash never gets a write path at all.
               next_fl_rd = (dec.region == iad_pkg::IAD_REG_FLASH) && !req.write;
               next_src_dm = data_ok && !req.write;
               next_src_fl = (dec.region == iad_pkg::IAD_REG_FLASH) && !req.write;
               next_is_flash = (dec.region == iad_pkg::IAD_REG_FLASH);
            end
         end
         iad_pkg::IAD_ST_ISSUE: begin
            // Memory registers the strobe on this edge and answers after it.
            next_state = iad_pkg::IAD_ST_CAPT;
         end
         iad_pkg::IAD_ST_CAPT: begin
            if (src_dm) begin
               next_rd_data = dm_rdata;
            end else if (src_fl) begin
               next_rd_data = fl_rdata[7:0];
            end else begin
               // Writes, port hits and holes all answer zero.
               next_rd_data = `IAD_READ_ZERO;
            end
            if (is_flash) begin
               // Flash costs one more cycle, even for a dropped write.
               next_state = iad_pkg::IAD_ST_EXTRA;
               next_stall = 1'b1;
            end else begin
               next_state = iad_pkg::IAD_ST_IDLE;
               next_busy = 1'b0;
               next_done = 1'b1;
            end
         end
         iad_pkg::IAD_ST_EXTRA: begin
            next_state = iad_pkg::IAD_ST_IDLE;
            next_busy = 1'b0;
            next_done = 1'b1;
         end
         default: begin
            next_state = iad_pkg::IAD_ST_IDLE;
            next_busy = 1'b0;
         end
      endcase
   end

   // Register stage; the reset values keep every strobe quiet.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state <= iad_pkg::IAD_ST_IDLE;
         busy <= 1'b0;
         done <= 1'b0;
         stall <= 1'b0;
         rd_data <= `IAD_READ_ZERO;
         dm_addr <= `IAD_DM_ADDR_RST;
         dm_rd <= 1'b0;
         dm_wr <= 1'b0;
         dm_wdata <= `IAD_READ_ZERO;
         fl_addr <= `IAD_FL_ADDR_RST;
         fl_rd <= 1'b0;
         src_dm <= 1'b0;
         src_fl <= 1'b0;
         is_flash <= 1'b0;
      end else begin
         state <= next_state;
         busy <= next_busy;
         done <= next_done;
         stall <= next_stall;
         rd_data <= next_rd_data;
         dm_addr <= next_dm_addr;
         dm_rd <= next_dm_rd;
         dm_wr <= next_dm_wr;
         dm_wdata <= next_dm_wdata;
         fl_addr <= next_fl_addr;
         fl_rd <= next_fl_rd;
         src_dm <= next_src_dm;
         src_fl <= next_src_fl;
         is_flash <= next_is_flash;
      end
   end

endmodule
`default_nettype wire

/* iad_defines.svh */
// Address map constants and reset values for the indirect address decoder.
`ifndef IAD_DEFINES_SVH
`define IAD_DEFINES_SVH

// Last pointer value of the traditional data memory region.
`define IAD_TRAD_LAST 16'h0fff
// First and last pointer values of the linear data memory region.
`define IAD_LIN_FIRST 16'h2000
`define IAD_LIN_LAST 16'h29af
// Size of one banked general-purpose RAM block, in bytes.
`define IAD_GPR_BYTES 12'h050
// Bank offset of the first general-purpose byte in every bank.
`define IAD_GPR_BASE 7'h20
// Highest in-bank offset that is an indirect access port location.
`define IAD_PORT_LAST 7'h01
// Bit of the pointer that selects the program flash region.
`define IAD_FLASH_BIT 15
// Value returned for every read that reaches no storage.
`define IAD_READ_ZERO 8'h00
// Reset value of the address outputs.
`define IAD_DM_ADDR_RST 12'h000
`define IAD_FL_ADDR_RST 15'h0000

`endif

/* iad_pkg.sv */
// Types shared by the indirect address decoder files.
package iad_pkg;

   // Region that a pointer value falls into.
   typedef enum logic [1:0] {
      IAD_REG_TRAD = 2'h0,
      IAD_REG_LIN = 2'h1,
      IAD_REG_FLASH = 2'h2,
      IAD_REG_NONE = 2'h3
   } iad_region_t;

   // The 16-bit pointer as its two bytes.
   typedef struct packed {
      logic [7:0] high;
      logic [7:0] low;
   } iad_ptr_t;

   // One indirect access request from the core.
   typedef struct packed {
      logic write;
      iad_ptr_t ptr;
      logic [7:0] wdata;
   } iad_req_t;

   // Result of decoding one pointer value.
   typedef struct packed {
      iad_region_t region;
      logic port_hit;
      logic [11:0] dm_addr;
      logic [14:0] fl_addr;
   } iad_dec_t;

   // Sequencer states, Gray coded along idle, issue, capture, extra.
   typedef enum logic [1:0] {
      IAD_ST_IDLE = 2'b00,
      IAD_ST_ISSUE = 2'b01,
      IAD_ST_CAPT = 2'b11,
      IAD_ST_EXTRA = 2'b10
   } iad_state_t;

endpackage

/* iad_decode.sv */
// Combinational pointer decoder: region, absolute data address and flash word address.
`timescale 1ns/1ps
`default_nettype none
`include "iad_defines.svh"

module iad_decode (
   // Pointer to decode.
   input wire iad_pkg::iad_ptr_t ptr,
   // Decoded result.
   output iad_pkg::iad_dec_t dec
);

   // Linear offset n lands in bank n/80 at bank offset 0x20 plus n mod 80.
   function automatic logic [11:0] lin_map(input logic [11:0] n);
      logic [11:0] bank;
      logic [11:0] rem;
      bank = n / `IAD_GPR_BYTES;
      rem = n % `IAD_GPR_BYTES;
      lin_map = {bank[4:0], 7'(`IAD_GPR_BASE + rem[6:0])};
   endfunction

   logic [15:0] full;
   logic [15:0] lin_off;

   // The two pointer bytes form one 16-bit address, high byte on top.
   assign full = {ptr.high, ptr.low};
   assign lin_off = full - `IAD_LIN_FIRST;

   // Region select; flash wins on the top bit, gaps count as unimplemented.
   always_comb begin
      dec.region = iad_pkg::IAD_REG_NONE;
      dec.port_hit = 1'b0;
      dec.dm_addr = `IAD_DM_ADDR_RST;
      dec.fl_addr = full[14:0];
      if (full[`IAD_FLASH_BIT]) begin
         dec.region = iad_pkg::IAD_REG_FLASH;
      end else if (full <= `IAD_TRAD_LAST) begin
         dec.region = iad_pkg::IAD_REG_TRAD;
         dec.dm_addr = full[11:0];
         // Offsets 0 and 1 of every bank are the port locations themselves.
         dec.port_hit = (full[6:0] <= `IAD_PORT_LAST);
      end else if (full >= `IAD_LIN_FIRST && full <= `IAD_LIN_LAST) begin
         dec.region = iad_pkg::IAD_REG_LIN;
         dec.dm_addr = lin_map(lin_off[11:0]);
      end
   end

endmodule
`default_nettype wire

/* iad_props.sv */
// Port checks for the indirect address decoder.
`timescale 1ns/1ps
`default_nettype none
module iad_props (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rst,
   // Core side.
   input wire logic req_valid,
   input wire logic busy,
   input wire logic done,
   input wire logic stall,
   input wire logic [7:0] rd_data,
   // Memory sides.
   input wire logic dm_rd,
   input wire logic dm_wr,
   input wire logic [7:0] dm_rdata,
   input wire logic fl_rd,
   input wire logic [13:0] fl_rdata
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // The low flash byte is split out so that $past sees a plain signal.
   logic [7:0] fl_low;
   assign fl_low = fl_rdata[7:0];
   a_take_busy: assert property (req_valid && !busy |-> ##[1:2] busy)
      else $error("request not taken");
   a_dm_done: assert property (dm_rd |=> !dm_rd ##1 done)
      else $error("data read did not finish on time");
   a_dm_data: assert property (dm_rd |=> ##1 rd_data == $past(dm_rdata))
      else $error("read data differs from memory");
   a_wr_zero: assert property (dm_wr |=> ##1 done && rd_data == 8'h00)
      else $error("write answer wrong");
   a_flash_low: assert property (fl_rd |=> ##1 stall && rd_data == $past(fl_low))
      else $error("flash byte wrong");
   a_stall_done: assert property (stall |=> done && !stall && !busy)
      else $error("extra cycle not followed by done");
   a_flash_excl: assert property (fl_rd |-> !dm_rd && !dm_wr)
      else $error("data strobe during flash access");
   a_busy_end: assert property ($fell(busy) |-> done)
      else $error("busy fell without done");
   c_read: cover property (dm_rd);
   c_write: cover property (dm_wr);
   c_flash: cover property (stall);
endmodule
bind iad_top iad_props u_iad_props (.sys_clk(sys_clk), .rst(rst), .req_valid(req_valid),
   .busy(busy), .done(done), .stall(stall), .rd_data(rd_data), .dm_rd(dm_rd), .dm_wr(dm_wr),
   .dm_rdata(dm_rdata), .fl_rd(fl_rd), .fl_rdata(fl_rdata));
`default_nettype wire

/* iad_mem_model.sv */
// Behavioural data memory and program flash that answer the decoder.
`timescale 1ns/1ps
`default_nettype none
module iad_mem_model (
   // Clock.
   input wire logic sys_clk,
   // Data memory port.
   input wire logic [11:0] dm_addr,
   input wire logic dm_rd,
   input wire logic dm_wr,
   input wire logic [7:0] dm_wdata,
   output logic [7:0] dm_rdata,
   // Flash port.
   input wire logic [14:0] fl_addr,
   input wire logic fl_rd,
   output logic [13:0] fl_rdata
);
   logic [7:0] mem [0:4095];
   // Preload a pattern that the bench can predict.
   initial begin
      for (int i = 0; i < 4096; i++) begin
         mem[i] = i[7:0] ^ 8'h5a;
      end
      dm_rdata = 8'h00;
      fl_rdata = 14'h0000;
   end
   // Data is valid only in the cycle after a strobe; it toggles otherwise so stale reads show.
   always @(posedge sys_clk) begin
      if (dm_wr) begin
         mem[dm_addr] <= dm_wdata;
      end
      dm_rdata <= dm_rd ? mem[dm_addr] : ~dm_rdata;
      fl_rdata <= fl_rd ? {6'h2a, fl_addr[7:0] ^ fl_addr[14:7]} : ~fl_rdata;
   end
endmodule
`default_nettype wire

/* testbench.sv */
// Self-checking bench for the indirect address decoder.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic req_valid = 1'b0;
   iad_pkg::iad_req_t req = '0;
   logic busy, done, stall, dm_rd, dm_wr, fl_rd;
   logic [7:0] rd_data, dm_wdata, dm_rdata, got;
   logic [11:0] dm_addr, seen_dm;
   logic [14:0] fl_addr, seen_fl;
   logic [13:0] fl_rdata;
   logic saw_rd, saw_wr, saw_fl, saw_st;
   int n_fail = 0;
   int cmp_count = 0;
   int lat;
   always #10 sys_clk = ~sys_clk;
   iad_top u_iad_top (.sys_clk(sys_clk), .rst(rst), .req_valid(req_valid), .req(req),
      .busy(busy), .done(done), .stall(stall), .rd_data(rd_data), .dm_addr(dm_addr),
      .dm_rd(dm_rd), .dm_wr(dm_wr), .dm_wdata(dm_wdata), .dm_rdata(dm_rdata),
      .fl_addr(fl_addr), .fl_rd(fl_rd), .fl_rdata(fl_rdata));
   iad_mem_model u_iad_mem_model (.sys_clk(sys_clk), .dm_addr(dm_addr), .dm_rd(dm_rd),
      .dm_wr(dm_wr), .dm_wdata(dm_wdata), .dm_rdata(dm_rdata), .fl_addr(fl_addr),
      .fl_rd(fl_rd), .fl_rdata(fl_rdata));
   task automatic chk(input logic ok, input string msg);
      cmp_count++;
      if (ok !== 1'b1) begin
         n_fail++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask
   // One access at a falling edge; the request stays up when another follows back to back.
   task automatic xfer(input logic wr, input logic [15:0] p, input logic [7:0] wd,
      input logic more, input logic [7:0] exp, input int lt);
      req = {wr, p, wd};
      req_valid = 1'b1;
      {saw_rd, saw_wr, saw_fl, saw_st} = 4'h0;
      lat = 0;
      do begin
         @(negedge sys_clk);
         lat++;
         if (dm_rd === 1'b1) seen_dm = dm_addr;
         if (fl_rd === 1'b1) seen_fl = fl_addr;
         saw_rd |= dm_rd === 1'b1;
         saw_wr |= dm_wr === 1'b1;
         saw_fl |= fl_rd === 1'b1;
         saw_st |= stall === 1'b1;
      end while (done !== 1'b1 && lat < 20);
      got = rd_data;
      chk(got === exp && lat == lt, "read data or latency");
      if (!more) begin
         req_valid = 1'b0;
         @(negedge sys_clk);
      end
   endtask
   task automatic t_trad();
      xfer(1'b1, 16'h0123, 8'h3c, 1'b1, 8'h00, 3);
      chk(saw_wr && !saw_rd && dm_addr === 12'h123, "write strobe");
      xfer(1'b0, 16'h0123, 8'h00, 1'b1, 8'h3c, 3);
      chk(seen_dm === 12'h123, "absolute address");
      xfer(1'b0, 16'h0fa5, 8'h00, 1'b0, 8'hff, 3);
      chk(seen_dm === 12'hfa5 && !saw_fl, "top address");
      $display("t_trad finished");
   endtask
   task automatic t_port_hole();
      logic [15:0] ptrs [8] = '{16'h0000, 16'h0001, 16'h0080, 16'h0f81, 16'h1000, 16'h1fff,
         16'h29b0, 16'h7fff};
      for (int i = 0; i < 8; i++) begin
         xfer(1'b1, ptrs[i], 8'hff, 1'b1, 8'h00, 3);
         chk(!saw_wr && !saw_rd, "suppressed write");
         xfer(1'b0, ptrs[i], 8'h00, i < 7, 8'h00, 3);
         chk(!saw_rd && !saw_fl, "no strobe on read");
      end
      $display("t_port_hole finished");
   endtask
   task automatic t_linear();
      logic [15:0] ptrs [5] = '{16'h2000, 16'h204f, 16'h2050, 16'h209f, 16'h29af};
      logic [11:0] ea;
      int n;
      for (int i = 0; i < 5; i++) begin
         n = ptrs[i] - 16'h2000;
         ea = {5'(n / 80), 7'(32 + n % 80)};
         xfer(1'b0, ptrs[i], 8'h00, 1'b1, ea[7:0] ^ 8'h5a, 3);
         chk(seen_dm === ea && seen_dm[6:0] < 7'h70, "linear address");
      end
      xfer(1'b1, 16'h2050, 8'h77, 1'b1, 8'h00, 3);
      xfer(1'b0, 16'h00a0, 8'h00, 1'b0, 8'h77, 3);
      $display("t_linear finished");
   endtask
   task automatic t_flash();
      xfer(1'b0, 16'h8123, 8'h00, 1'b1, 8'h21, 4);
      chk(saw_fl && saw_st && !saw_rd && seen_fl === 15'h0123, "flash read");
      xfer(1'b0, 16'hffff, 8'h00, 1'b1, 8'h00, 4);
      chk(seen_fl === 15'h7fff, "top flash word");
      xfer(1'b1, 16'h8005, 8'h55, 1'b0, 8'h00, 4);
      chk(!saw_fl && !saw_wr && saw_st, "flash write ignored");
      $display("t_flash finished");
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // The tests need about 110 cycles; the watchdog allows 5000, over forty times that.
   initial begin
      #(20 * 5000);
      n_fail++;
      complete_run();
   end
   // Reset, then every scenario in turn.
   initial begin
      repeat (16) @(posedge sys_clk);
      @(negedge sys_clk);
      rst = 1'b0;
      t_trad();
      t_port_hole();
      t_linear();
      t_flash();
      complete_run();
   end
endmodule
`default_nettype wire
